// file: rtl/cpb_bus_seq.sv
/*
 * local bus sequencer: non-pipelined and pipelined address timing and the
 * locked pair of interrupt acknowledge cycles with the vector capture.
 * assumes an internal requester that holds req_valid with stable fields until
 * req_taken, and external decode logic that answers on ready_n.
 */
`timescale 1ns/1ps
module cpb_bus_seq #(
    parameter int ADDR_W = cpb_pkg::ADDR_W,
    parameter int DATA_W = cpb_pkg::DATA_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // internal bus request
    input wire logic req_valid,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic req_hi_en_n,
    input wire logic req_lo_en_n,
    input wire logic req_wr,
    input wire logic req_dc,
    input wire logic req_mio,
    input wire logic req_lock,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_taken,
    // read return
    output logic [DATA_W-1:0] rd_data,
    output logic rd_valid,
    // interrupt side
    input wire logic interrupt_request_input,
    input wire logic int_enable,
    output logic [cpb_pkg::VEC_W-1:0] int_vector,
    output logic int_vector_valid,
    // bus pins
    output logic address_strobe_n,
    output logic [ADDR_W-1:0] addr_out,
    output logic upper_byte_enable_n,
    output logic lower_byte_enable_n,
    output logic wr_out,
    output logic dc_out,
    output logic mio_out,
    output logic bus_lock_n,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic ready_n,
    input wire logic next_address_request_n
);
    if (ADDR_W < 3 || DATA_W < cpb_pkg::VEC_W) begin : g_chk
        $error("cpb_bus_seq needs at least 3 address bits and 8 data bits");
    end

    localparam int SW = DATA_W + 3;

    logic ph1_end;
    logic state_end;
    logic [SW-1:0] pin_sync;
    logic ready_s_n;
    logic na_s_n;
    logic interrupt_request_input_s;
    logic [DATA_W-1:0] data_s;
    cpb_pkg::cpb_state_t st;
    cpb_pkg::cpb_state_t next_st;
    cpb_pkg::cpb_ia_t ia;
    cpb_pkg::cpb_kind_t cur_kind;
    cpb_pkg::cpb_kind_t nxt_kind;
    cpb_pkg::cpb_kind_t launch_kind;
    logic cur_wr;
    logic nxt_wr;
    logic [DATA_W-1:0] cur_wdata;
    logic [DATA_W-1:0] nxt_wdata;
    logic na_seen;
    logic drop_pending;
    logic [2:0] gap_cnt;

    // clock phases
    cpb_phase_gen u_phase (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ph1_end(ph1_end),
        .state_end(state_end)
    );

    // pin inputs through two flip-flops
    cpb_sync #(
        .WIDTH(SW)
    ) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pin_in({ready_n, next_address_request_n, interrupt_request_input, data_in}),
        .sync_out(pin_sync),
        .reset_value({2'b11, 1'b0, {DATA_W{1'b0}}}) // ready and next-address idle high
    );

    assign ready_s_n = pin_sync[SW-1];
    assign na_s_n = pin_sync[SW-2];
    assign interrupt_request_input_s = pin_sync[SW-3];
    assign data_s = pin_sync[DATA_W-1:0];

    // request selection: acknowledges first, others held off during the sequence
    wire gap_done = (ia == cpb_pkg::IA_GAP) && (st == cpb_pkg::ST_IDLE) && (gap_cnt == cpb_pkg::GAP_LAST);
    wire ack1_want = (ia == cpb_pkg::IA_ACK1_WAIT);
    wire pending = ack1_want || gap_done || (req_valid && ia == cpb_pkg::IA_NONE);
    assign launch_kind = ack1_want ? cpb_pkg::KIND_ACK1 : (gap_done ? cpb_pkg::KIND_ACK2 : cpb_pkg::KIND_NORMAL);
    wire is_ack = (launch_kind != cpb_pkg::KIND_NORMAL);
    wire [ADDR_W-1:0] l_addr = ack1_want ? ADDR_W'(cpb_pkg::ACK1_ADDR) :
                               (gap_done ? ADDR_W'(cpb_pkg::ACK2_ADDR) : req_addr);
    wire l_hi_n = is_ack ? 1'b1 : req_hi_en_n;
    wire l_lo_n = is_ack ? 1'b0 : req_lo_en_n;
    wire l_wr = is_ack ? cpb_pkg::ACK_WR : req_wr;
    wire l_dc = is_ack ? cpb_pkg::ACK_DC : req_dc;
    wire l_mio = is_ack ? cpb_pkg::ACK_MIO : req_mio;

    // ready is looked at in the second state of a cycle and its waits
    wire in_second = (st == cpb_pkg::ST_SECOND) || (st == cpb_pkg::ST_SECOND_WAITADDR) ||
                     (st == cpb_pkg::ST_PIPE_SECOND);
    wire cur_ack = state_end && in_second && !ready_s_n;
    wire na_window = (st == cpb_pkg::ST_SECOND) || (st == cpb_pkg::ST_PIPE_FIRST);

    // next bus state
    always_comb begin
        next_st = st;
        case (st)
            cpb_pkg::ST_IDLE: begin
                next_st = pending ? cpb_pkg::ST_FIRST : cpb_pkg::ST_IDLE;
            end
            cpb_pkg::ST_FIRST: begin
                next_st = cpb_pkg::ST_SECOND;
            end
            cpb_pkg::ST_SECOND, cpb_pkg::ST_PIPE_FIRST: begin
                if (st == cpb_pkg::ST_SECOND && !ready_s_n) begin
                    next_st = pending ? cpb_pkg::ST_FIRST : cpb_pkg::ST_IDLE;
                end else if (na_seen) begin
                    next_st = pending ? cpb_pkg::ST_PIPE_SECOND : cpb_pkg::ST_SECOND_WAITADDR;
                end else begin
                    next_st = cpb_pkg::ST_SECOND;
                end
            end
            cpb_pkg::ST_SECOND_WAITADDR: begin
                if (!ready_s_n) begin
                    next_st = pending ? cpb_pkg::ST_FIRST : cpb_pkg::ST_IDLE;
                end else if (pending) begin
                    next_st = cpb_pkg::ST_PIPE_SECOND;
                end
            end
            cpb_pkg::ST_PIPE_SECOND: begin
                if (!ready_s_n) begin
                    next_st = cpb_pkg::ST_PIPE_FIRST;
                end
            end
            default: begin
                next_st = cpb_pkg::ST_IDLE;
            end
        endcase
    end

    // a new address goes out only when entering first or pipelined second state
    wire launch = state_end && (next_st == cpb_pkg::ST_FIRST ||
                  (next_st == cpb_pkg::ST_PIPE_SECOND && st != cpb_pkg::ST_PIPE_SECOND));
    wire launch_pipe = launch && (next_st == cpb_pkg::ST_PIPE_SECOND);
    wire launch_direct = launch && (next_st == cpb_pkg::ST_FIRST);

    // bus state register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st <= cpb_pkg::ST_IDLE;
        end else if (state_end) begin
            st <= next_st;
        end
    end

    // next-address sampling at the end of phase one, first active sample sticks
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            na_seen <= 1'b0;
        end else if (ph1_end && na_window && !na_s_n) begin
            na_seen <= 1'b1;
        end else if (state_end && next_st != cpb_pkg::ST_SECOND && next_st != cpb_pkg::ST_SECOND_WAITADDR &&
                     next_st != cpb_pkg::ST_PIPE_SECOND) begin
            na_seen <= 1'b0;
        end
    end

    // address, definition and strobe pins
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            address_strobe_n <= 1'b1;
            addr_out <= '0;
            upper_byte_enable_n <= 1'b1;
            lower_byte_enable_n <= 1'b1;
            wr_out <= 1'b0;
            dc_out <= 1'b0;
            mio_out <= 1'b0;
        end else if (state_end) begin
            address_strobe_n <= !launch;
            if (launch) begin
                addr_out <= l_addr;
                upper_byte_enable_n <= l_hi_n;
                lower_byte_enable_n <= l_lo_n;
                wr_out <= l_wr;
                dc_out <= l_dc;
                mio_out <= l_mio;
            end
        end
    end

    // bus lock across both acknowledges and the gap
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bus_lock_n <= 1'b1;
        end else if (launch) begin
            bus_lock_n <= !(is_ack || req_lock);
        end else if (cur_ack && cur_kind == cpb_pkg::KIND_ACK2) begin
            bus_lock_n <= 1'b1;
        end
    end

    // current and pipelined cycle bookkeeping
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cur_kind <= cpb_pkg::KIND_NORMAL;
            nxt_kind <= cpb_pkg::KIND_NORMAL;
            cur_wr <= 1'b0;
            nxt_wr <= 1'b0;
            cur_wdata <= '0;
            nxt_wdata <= '0;
        end else begin
            if (launch_direct) begin
                cur_kind <= launch_kind;
                cur_wr <= l_wr;
                cur_wdata <= req_wdata;
            end else if (cur_ack && st == cpb_pkg::ST_PIPE_SECOND) begin
                cur_kind <= nxt_kind;
                cur_wr <= nxt_wr;
                cur_wdata <= nxt_wdata;
            end
            if (launch_pipe) begin
                nxt_kind <= launch_kind;
                nxt_wr <= l_wr;
                nxt_wdata <= req_wdata;
            end
        end
    end

    // write data: driven from phase two of the first state to phase one after ready
    wire first_like = (st == cpb_pkg::ST_FIRST) || (st == cpb_pkg::ST_PIPE_FIRST);
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            data_oe <= 1'b0;
            data_out <= '0;
            drop_pending <= 1'b0;
        end else begin
            if (cur_ack && cur_wr) begin
                drop_pending <= 1'b1;
            end else if (ph1_end) begin
                drop_pending <= 1'b0;
            end
            if (ph1_end && first_like && cur_wr && cur_kind == cpb_pkg::KIND_NORMAL) begin
                data_oe <= 1'b1;
                data_out <= cur_wdata;
            end else if (ph1_end && drop_pending) begin
                data_oe <= 1'b0;
            end
        end
    end

    // read data and vector capture at the acknowledge
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rd_data <= '0;
            rd_valid <= 1'b0;
            int_vector <= '0;
            int_vector_valid <= 1'b0;
            req_taken <= 1'b0;
        end else begin
            rd_valid <= cur_ack && !cur_wr && cur_kind == cpb_pkg::KIND_NORMAL;
            int_vector_valid <= cur_ack && cur_kind == cpb_pkg::KIND_ACK2;
            req_taken <= launch && launch_kind == cpb_pkg::KIND_NORMAL;
            if (cur_ack && !cur_wr && cur_kind == cpb_pkg::KIND_NORMAL) begin
                rd_data <= data_s;
            end
            if (cur_ack && cur_kind == cpb_pkg::KIND_ACK2) begin
                int_vector <= data_s[cpb_pkg::VEC_W-1:0];
            end
        end
    end

    // interrupt acknowledge sequence
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ia <= cpb_pkg::IA_NONE;
            gap_cnt <= '0;
        end else begin
            case (ia)
                cpb_pkg::IA_NONE: begin
                    if (interrupt_request_input_s && int_enable) begin
                        ia <= cpb_pkg::IA_ACK1_WAIT;
                    end
                end
                cpb_pkg::IA_ACK1_WAIT: begin
                    if (launch) begin
                        ia <= cpb_pkg::IA_ACK1_RUN;
                    end
                end
                cpb_pkg::IA_ACK1_RUN: begin
                    if (cur_ack && cur_kind == cpb_pkg::KIND_ACK1) begin
                        ia <= cpb_pkg::IA_GAP;
                        gap_cnt <= '0;
                    end
                end
                cpb_pkg::IA_GAP: begin
                    if (launch) begin
                        ia <= cpb_pkg::IA_ACK2_RUN;
                    end else if (state_end && st == cpb_pkg::ST_IDLE) begin
                        gap_cnt <= gap_cnt + 3'h1;
                    end
                end
                cpb_pkg::IA_ACK2_RUN: begin
                    if (cur_ack && cur_kind == cpb_pkg::KIND_ACK2) begin
                        ia <= cpb_pkg::IA_NONE;
                    end
                end
                default: begin
                    ia <= cpb_pkg::IA_NONE;
                end
            endcase
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_new_addr;
        $fell(address_strobe_n);
    endsequence

    a_idle_then_first: assert property (st != cpb_pkg::ST_IDLE && $past(st) == cpb_pkg::ST_IDLE
        |-> st == cpb_pkg::ST_FIRST) else $error("cycle after idle not non-pipelined");
    a_pipe_entry: assert property ($rose(st == cpb_pkg::ST_PIPE_FIRST)
        |-> $past(st) == cpb_pkg::ST_PIPE_SECOND) else $error("pipelined first state without pipelined second");
    a_pipe_two_state: assert property ($rose(st == cpb_pkg::ST_PIPE_FIRST)
        |-> ##2 st != cpb_pkg::ST_PIPE_FIRST) else $error("pipelined first state longer than one state");
    a_addr_stable: assert property (s_new_addr |=> (!address_strobe_n && $stable(addr_out))
        ##1 ($stable(addr_out) && address_strobe_n) [*2])
        else $error("address changed within two processor clocks");
    a_strobe_on_pipe: assert property ($rose(st == cpb_pkg::ST_PIPE_SECOND) |-> !address_strobe_n)
        else $error("pipelined second state without strobe");
    a_na_phase_one: assert property ($rose(na_seen) |-> $past(ph1_end && na_window))
        else $error("next-address sampled outside phase one");
    a_ack1_addr: assert property ($rose(st == cpb_pkg::ST_FIRST) && ia == cpb_pkg::IA_ACK1_RUN
        |-> addr_out == cpb_pkg::ACK1_ADDR && !lower_byte_enable_n && upper_byte_enable_n && !bus_lock_n)
        else $error("first acknowledge address wrong");
    a_lock_gap: assert property (ia == cpb_pkg::IA_GAP |-> !bus_lock_n)
        else $error("lock dropped between acknowledges");
    a_gap_four: assert property ($rose(ia == cpb_pkg::IA_ACK2_RUN) |-> $past(st == cpb_pkg::ST_IDLE, 8)
        && $past(st != cpb_pkg::ST_IDLE, 9) && addr_out == cpb_pkg::ACK2_ADDR)
        else $error("gap between acknowledges not four idle states");
    a_ack_float: assert property (st == cpb_pkg::ST_SECOND && cur_kind != cpb_pkg::KIND_NORMAL |-> !data_oe)
        else $error("data driven during acknowledge");
endmodule : cpb_bus_seq

// file: rtl/cpb_pkg.sv
/*
 * constants, states and cycle kinds for the local bus sequencer with
 * address pipelining and the two-cycle interrupt acknowledge.
 * assumes one clock at twice the processor clock rate; a bus state is two clocks.
 */
package cpb_pkg;
    localparam int ADDR_W = 23;                 // address pins, byte address bits 23..1
    localparam int DATA_W = 16;
    localparam int VEC_W = 8;
    localparam int CLK_PERIOD_PS = 25000;       // clk_sys at 40 MHz
    localparam int CLKS_PER_STATE = 2;          // one processor clock per bus state
    localparam int GAP_STATES = 4;              // idle states between acknowledges
    localparam logic [ADDR_W-1:0] ACK1_ADDR = 23'h000002; // byte address 4
    localparam logic [ADDR_W-1:0] ACK2_ADDR = 23'h000000; // byte address 0
    localparam logic ACK_WR = 1'b0;             // acknowledge cycle definition levels
    localparam logic ACK_DC = 1'b0;
    localparam logic ACK_MIO = 1'b0;
    localparam logic [2:0] GAP_LAST = 3'(GAP_STATES - 1);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FIRST,
        ST_SECOND,
        ST_SECOND_WAITADDR,
        ST_PIPE_FIRST,
        ST_PIPE_SECOND
    } cpb_state_t;

    typedef enum logic [1:0] {
        KIND_NORMAL,
        KIND_ACK1,
        KIND_ACK2
    } cpb_kind_t;

    typedef enum logic [2:0] {
        IA_NONE,
        IA_ACK1_WAIT,
        IA_ACK1_RUN,
        IA_GAP,
        IA_ACK2_RUN
    } cpb_ia_t;
endpackage : cpb_pkg

// file: rtl/cpb_sync.sv
/*
 * two flip-flop synchroniser for a group of pin inputs.
 * assumes the pins are asynchronous to clk_sys and tolerate two clocks of delay.
 */
`timescale 1ns/1ps
module cpb_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // pins in, synchronised out
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] sync_out,
    input wire logic [WIDTH-1:0] reset_value
);
    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1) begin : g_chk
        $error("cpb_sync width must be at least one");
    end

    // first stage feeds the second only
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            stage1 <= reset_value;
            sync_out <= reset_value;
        end else begin
            stage1 <= pin_in;
            sync_out <= stage1;
        end
    end
endmodule : cpb_sync

// file: rtl/cpb_phase_gen.sv
/*
 * divides clk_sys into processor clock phases: one pulse at the end of
 * phase one and one at the end of the bus state.
 * assumes the phase is defined by the release of reset.
 */
`timescale 1ns/1ps
module cpb_phase_gen (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // phase enables
    output logic ph1_end,
    output logic state_end
);
    logic phase;

    // phase low is phase one, high is phase two
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
        end
    end

    assign ph1_end = ~phase;
    assign state_end = phase;
endmodule : cpb_phase_gen

// file: verif/cpb_partner.sv
/*
 * far-side model: memory, i/o and interrupt decode answering the bus sequencer.
 * assumes a bus state is two clk_sys periods, the first edge after reset ending phase one.
 */
`timescale 1ns/1ps
module cpb_partner (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // sequencer pins
    input wire logic address_strobe_n,
    input wire logic [cpb_pkg::ADDR_W-1:0] addr_out,
    input wire logic wr_out,
    input wire logic bus_lock_n,
    input wire logic [15:0] data_out,
    output logic ready_n,
    output logic next_address_request_n,
    output logic [15:0] data_in,
    // bench controls and counts
    input wire logic [1:0] waits,
    input wire logic na_on,
    input wire logic [7:0] vec,
    output int pipe_seen,
    output int deep_seen
);
    logic ph;
    logic land;
    logic [24:0] ent;
    logic rdy;
    logic [15:0] dnext;
    logic [24:0] q[$];
    logic [15:0] mem[16];
    int wcnt;

    // bus state phase, restarted by reset
    always @(posedge clk_sys) ph <= reset_n ? ~ph : 1'b0;

    // one decision per bus state, just after it starts
    always @(negedge clk_sys) begin
        if (!reset_n) begin
            ready_n <= 1'b1;
            next_address_request_n <= 1'b1;
            data_in <= 16'h0000;
            q.delete();
            land = 1'b0;
            wcnt = 0;
            pipe_seen = 0;
            deep_seen = 0;
        end else if (!ph) begin
            rdy = 1'b1;
            dnext = ~data_in; // released bus never repeats a value
            // only the strobe counts as a new cycle
            if (!address_strobe_n) begin
                if (q.size() + land == 1) pipe_seen++;
                if (q.size() + land > 1) deep_seen++;
                q.push_back({!bus_lock_n, wr_out, addr_out});
            end
            if (land) begin
                if (ent[23]) mem[ent[3:0]] = data_out; // write data still driven here
                land = 1'b0;
            end else if (q.size() > 0 && wcnt >= waits) begin
                ent = q.pop_front();
                rdy = 1'b0;
                // locked cycles: first acknowledge offers a decoy that must not be taken
                if (ent[24]) dnext = {8'h00, ent[1] ? ~vec : vec};
                else if (!ent[23]) dnext = mem[ent[3:0]];
                land = 1'b1;
                wcnt = 0;
            end else if (q.size() > 0) begin
                wcnt++;
            end
            ready_n <= rdy;
            next_address_request_n <= ~na_on;
            data_in <= dnext;
        end
    end
endmodule : cpb_partner

// file: verif/tb_top.sv
/*
 * bench for the bus sequencer: random reads and writes without and with
 * address pipelining, then masked and locked interrupt acknowledge pairs.
 * assumes the partner model answers every strobed cycle.
 */
`timescale 1ns/1ps
module tb_top;
    logic clk_sys, reset_n, req_valid, req_wr, req_dc, req_mio, req_taken, rd_valid;
    logic interrupt_request_input, int_enable, int_vector_valid, address_strobe_n;
    logic upper_byte_enable_n, lower_byte_enable_n, wr_out, dc_out, mio_out, bus_lock_n;
    logic data_oe, ready_n, next_address_request_n, na_on;
    logic [cpb_pkg::ADDR_W-1:0] req_addr, addr_out;
    logic [cpb_pkg::ADDR_W-1:0] last_addr = 23'h000000;
    logic [15:0] req_wdata, rd_data, data_out, data_in;
    logic [15:0] known = 16'h0000;
    logic [15:0] model[16];
    logic [15:0] rdq[$];
    logic [7:0] int_vector, vec;
    logic [1:0] waits;
    logic prev_stb = 1'b1;
    logic in_ack = 1'b0;
    int pipe_seen, deep_seen, error_cnt, samples_checked, seed, i, t_ack1, ack_w;
    int cyc = 0;
    int last_stb = -100;
    int n_ack = 0;

    cpb_bus_seq dut (.*, .req_hi_en_n(1'b0), .req_lo_en_n(1'b0), .req_lock(1'b0));
    cpb_partner far (.*);

    // clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic end_test(input string name);
        $display("test %s finished, mismatches so far %0d", name, error_cnt);
    endtask : end_test

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // one request held until taken; unknown words are written first
    task automatic bus_op(input logic [3:0] a, input logic wr);
        int n;
        req_valid <= 1'b1;
        req_wr <= wr | !known[a];
        req_addr <= {19'($random(seed)), a};
        req_wdata <= 16'($random(seed));
        req_dc <= 1'($random(seed));
        req_mio <= 1'($random(seed));
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (req_taken !== 1'b1 && n < 300);
        chk(n < 300, "request never taken");
        if (req_wr) begin
            model[a] = req_wdata;
            known[a] = 1'b1;
        end else begin
            rdq.push_back(model[a]);
        end
    endtask : bus_op

    // bus watcher at the settled falling edge
    always @(negedge clk_sys) begin
        cyc++;
        if (reset_n === 1'b1) begin
            if (rd_valid === 1'b1) begin
                chk(rdq.size() > 0 && rd_data === rdq[0], "read data");
                if (rdq.size() > 0) rdq.delete(0);
            end
            if (address_strobe_n === 1'b0 && prev_stb === 1'b1) begin
                chk(cyc - last_stb >= 4, "strobes too close");
                last_stb = cyc;
                last_addr = addr_out;
                if (bus_lock_n === 1'b0) begin
                    chk({upper_byte_enable_n, lower_byte_enable_n, wr_out, dc_out, mio_out} ===
                        {2'b10, cpb_pkg::ACK_WR, cpb_pkg::ACK_DC, cpb_pkg::ACK_MIO}, "ack kind");
                    if (in_ack !== 1'b1) begin
                        chk(addr_out === 23'h000002, "first ack address");
                        t_ack1 = cyc;
                    end else begin
                        chk(addr_out === 23'h000000 && cyc - t_ack1 == 12 + 2 * ack_w, "second ack");
                    end
                    in_ack = 1'b1;
                end else begin
                    chk({addr_out, upper_byte_enable_n, lower_byte_enable_n, wr_out, dc_out, mio_out} ===
                        {req_addr, 2'b00, req_wr, req_dc, req_mio}, "cycle address");
                end
            end else begin
                chk(addr_out === last_addr, "address moved without strobe");
            end
            if (in_ack === 1'b1 && int_vector_valid !== 1'b1)
                chk(bus_lock_n === 1'b0 && data_oe === 1'b0, "lock dropped or data driven");
            if (int_vector_valid === 1'b1) begin
                chk(int_vector === vec, "vector");
                in_ack = 1'b0;
                n_ack++;
            end
        end
        prev_stb = address_strobe_n;
    end

    // watchdog
    initial begin
        #1500000;
        error_cnt++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        print_verdict();
    end

    // main sequence
    initial begin
        seed = 90196;
        {reset_n, req_valid, req_wr, req_dc, req_mio, na_on} = 6'h00;
        {interrupt_request_input, int_enable} = 2'h0;
        req_addr = 23'h000000;
        req_wdata = 16'h0000;
        waits = 2'h0;
        vec = 8'h00;
        repeat (6) @(negedge clk_sys);
        reset_n <= 1'b1;
        for (i = 0; i < 120; i++) begin
            if (i == 40) begin
                req_valid <= 1'b0;
                repeat (8) @(negedge clk_sys);
                chk(pipe_seen == 0, "pipelined without next address");
                end_test("plain cycles");
                na_on <= 1'b1;
            end
            waits <= 2'($random(seed));
            if (i > 60 && $random(seed) % 5 == 0) begin
                req_valid <= 1'b0;
                repeat (3) @(negedge clk_sys);
            end
            bus_op(4'($random(seed)), 1'($random(seed)));
        end
        req_valid <= 1'b0;
        repeat (20) @(negedge clk_sys);
        chk(pipe_seen > 0 && deep_seen == 0 && rdq.size() == 0, "pipelining");
        end_test("pipelined cycles");
        na_on <= 1'b0;
        interrupt_request_input <= 1'b1;
        repeat (40) @(negedge clk_sys);
        chk(n_ack == 0 && in_ack === 1'b0, "acknowledge while masked");
        for (i = 0; i < 2; i++) begin
            ack_w = 2 * i;
            waits <= 2'(ack_w);
            vec <= 8'($random(seed));
            interrupt_request_input <= 1'b1;
            int_enable <= 1'b1;
            repeat (200) if (in_ack !== 1'b1) @(negedge clk_sys);
            interrupt_request_input <= 1'b0;
            repeat (200) if (n_ack != i + 1) @(negedge clk_sys);
            chk(n_ack == i + 1, "acknowledge pair incomplete");
        end
        end_test("interrupt acknowledge");
        print_verdict();
    end
endmodule : tb_top
